// [core/lad_pkg.sv]
package lad_pkg;

  // ---------------------------------------------------------------
  // Link and sample geometry
  // ---------------------------------------------------------------
  localparam int unsigned DATA_PAIRS  = 14;
  localparam int unsigned SPARE_PAIRS = 14;
  localparam int unsigned SER_LANES   = 8;
  localparam int unsigned DDR_BIT_PRS = 8;
  localparam int unsigned CH2_PAIRS   = 7;
  localparam int unsigned NUM_CH      = 8;
  localparam int unsigned NUM_HDR     = 8;
  localparam int unsigned SER_HDRS    = 4;
  localparam int unsigned WIDE_HDRS   = 2;
  localparam int unsigned SAMPLE_W    = 16;
  localparam int unsigned WIDE_W      = 16;
  localparam int unsigned NARROW_W    = 14;
  localparam int unsigned HALF_W      = 8;
  localparam int unsigned HDR_POSTS   = 20;
  localparam int unsigned SKIP_FIRST  = 3;
  localparam int unsigned SKIP_OTHER  = 1;

  // ---------------------------------------------------------------
  // Timing
  // ---------------------------------------------------------------
  localparam int unsigned CLK_MHZ      = 40;
  localparam int unsigned CLK_HZ       = 40_000_000;
  localparam int unsigned SPI_HALF_NS  = 100;
  localparam int unsigned SPI_HALF_CYC = (SPI_HALF_NS * CLK_MHZ + 999) / 1000;
  localparam int unsigned SPI_BITS     = 16;
  localparam int unsigned BAUD_LOW     = 115_200;
  localparam int unsigned BAUD_MID     = 230_400;
  localparam int unsigned BAUD_HIGH    = 460_800;
  localparam logic [9:0]  DIV_LOW      = 10'(CLK_HZ / BAUD_LOW);
  localparam logic [9:0]  DIV_MID      = 10'(CLK_HZ / BAUD_MID);
  localparam logic [9:0]  DIV_HIGH     = 10'(CLK_HZ / BAUD_HIGH);
  localparam int unsigned UART_BITS    = 10;
  localparam logic [1:0]  HDR_CLK_HIGH = 2'h2;

  // ---------------------------------------------------------------
  // Capture storage and reset values
  // ---------------------------------------------------------------
  localparam int unsigned CAP_DEPTH     = 16;
  localparam int unsigned CAP_AW        = 4;
  localparam logic        SEL_N_IDLE    = 1'b1;
  localparam logic        CONV_RST_IDLE = 1'b0;
  localparam logic        CONV_PDN_IDLE = 1'b0;
  localparam logic        TX_IDLE       = 1'b1;

  // ---------------------------------------------------------------
  // Types
  // ---------------------------------------------------------------
  typedef enum logic [4:0] {
    FMT_DDR_BIT1 = 5'h01,
    FMT_DDR_SMP1 = 5'h02,
    FMT_DDR_BIT2 = 5'h04,
    FMT_SER_1W   = 5'h08,
    FMT_SER_2W   = 5'h10
  } lad_fmt_e;

  typedef enum logic [1:0] {
    BAUD_SEL_LOW  = 2'h0,
    BAUD_SEL_MID  = 2'h1,
    BAUD_SEL_HIGH = 2'h2
  } lad_baud_e;

  typedef enum logic [2:0] {
    CAP_IDLE = 3'h1,
    CAP_FILL = 3'h2,
    CAP_SEND = 3'h4
  } lad_cap_e;

  typedef struct packed {
    logic [NUM_CH-1:0][SAMPLE_W-1:0] ch;
  } lad_set_s;

  typedef struct packed {
    logic                start;
    logic [SPI_BITS-1:0] word;
  } lad_spi_req_s;

  typedef struct packed {
    logic select_n;
    logic sclk;
    logic config_serial_data;
  } lad_spi_s;

  typedef logic [HDR_POSTS-1:0] lad_posts_t;

endpackage

// [core/lad_sync.sv]
`timescale 1ns/10ps
`default_nettype none
module lad_sync #(
  parameter int unsigned W = 1
) (
  input  wire logic         i_clock,  // Destination clock
  input  wire logic         i_rst,    // Synchronous reset, active high
  input  wire logic [W-1:0] i_d,      // Level from another domain
  output logic      [W-1:0] o_q       // Synchronised level
);
  logic [W-1:0] meta_q;

  // First stage feeds only the second stage
  always_ff @(posedge i_clock) begin
    if (i_rst) begin
      meta_q <= '0;
      o_q    <= '0;
    end else begin
      meta_q <= i_d;
      o_q    <= meta_q;
    end
  end
endmodule
`default_nettype wire

// [core/lad_lane.sv]
`timescale 1ns/10ps
`default_nettype none
module lad_lane
  import lad_pkg::*;
(
  input  wire logic                i_clock,      // Link bit clock
  input  wire logic                i_rst,        // Link-domain reset
  input  wire logic                i_bit,        // Serial lane from pin
  input  wire logic                i_frame_edge, // Frame boundary, already 2 stages late
  output logic      [SAMPLE_W-1:0] o_word        // Last complete word
);
  logic [1:0]          dly_q;
  logic [SAMPLE_W-1:0] shift_q;

  // Match the two-stage delay of the frame path
  always_ff @(posedge i_clock) begin
    if (i_rst) begin
      dly_q <= '0;
    end else begin
      dly_q <= {dly_q[0], i_bit};
    end
  end

  // Clearing on every boundary bounds a slip to one word
  always_ff @(posedge i_clock) begin
    if (i_rst) begin
      shift_q <= '0;
      o_word  <= '0;
    end else if (i_frame_edge) begin
      o_word  <= shift_q;
      shift_q <= {{(SAMPLE_W-1){1'b0}}, dly_q[1]};
    end else begin
      shift_q <= {shift_q[SAMPLE_W-2:0], dly_q[1]};
    end
  end
endmodule
`default_nettype wire

// [core/lad_top.sv]
// Function
// - DDR bit clock gives one sample per period
// - Serial lanes shifted by bit clock, made parallel
// - Frame clock marks serial sample boundaries
// - Frame clock ignored in DDR formats
// - Fourteen data pairs, receive only
// - DDR bit-wise: eight pairs, 16-bit samples
// - DDR sample-wise: fourteen pairs, 14-bit samples
// - Two-channel DDR bit-wise uses fourteen pairs
// - Serial: eight lanes, one- or two-wire channels
// - Serial ignores pairs beyond eight
// - Spare pairs accepted, contents unused
// - Drive SPI select, clock, data to converter
// - Converter reset and power-down held inactive
// - Header stream and fixed-length capture record
// - Header: clock, skip, data from LSB up
// - Two 16-bit headers, six 14-bit headers
// - DDR headers disabled unless enabled
// - Serial drives four headers, channel per header
// - Eight-channel bank select; headers 5-8 unused
// - Clear empties capture store, keeps configuration
// - Start fills capture, then streams to host
// - Host link baud 115K, 230K or 460K
`timescale 1ns/10ps
`default_nettype none
module lad_top (
  input  wire logic                                      i_clock,         // System clock
  input  wire logic                                      i_sys_rst,       // Sync reset
  input  wire logic                                      i_bit_clock,     // Link bit clock
  input  wire logic                                      i_frame_clock_in,// Frame clock
  input  wire logic [lad_pkg::DATA_PAIRS-1:0]            i_data_pairs,    // Data pairs
  input  wire logic [lad_pkg::SPARE_PAIRS-1:0]           i_spare_pairs,   // Spare pairs
  input  wire lad_pkg::lad_fmt_e                         i_format,        // Link format
  input  wire logic                                      i_fall_first,    // Edge order
  input  wire logic                                      i_ddr_hdr_en,    // DDR headers on
  input  wire logic                                      i_upper_bank,    // Ch 5-8 select
  input  wire lad_pkg::lad_spi_req_s                     i_spi_req,       // SPI write
  input  wire logic                                      i_cap_start,     // Capture start
  input  wire logic [2:0]                                i_cap_chan,      // Capture channel
  input  wire logic [lad_pkg::CAP_AW:0]                  i_cap_len,       // Record length
  input  wire logic                                      i_fifo_clear,    // Empty store
  input  wire lad_pkg::lad_baud_e                        i_baud_sel,      // Host baud
  output lad_pkg::lad_posts_t [lad_pkg::NUM_HDR-1:0]     o_header,        // Header posts
  output lad_pkg::lad_spi_s                              o_spi,           // Converter SPI
  output logic                                           o_spi_busy,      // SPI active
  output logic                                           o_conv_reset,    // Converter reset
  output logic                                           o_conv_pdn,      // Converter pdn
  output logic                                           o_uart_tx,       // Host serial out
  output lad_pkg::lad_cap_e                              o_cap_state      // Capture state
);
  import lad_pkg::*;

  // ---------------------------------------------------------------
  // Shared decoding
  // ---------------------------------------------------------------
  function automatic logic [SAMPLE_W-1:0] interleave(input logic [HALF_W-1:0] ev,
                                                     input logic [HALF_W-1:0] od);
    logic [SAMPLE_W-1:0] r;
    r = '0;
    for (int k = 0; k < HALF_W; k++) begin
      r[2*k]   = ev[k];
      r[2*k+1] = od[k];
    end
    return r;
  endfunction

  function automatic lad_posts_t posts(input logic clk, input logic [SAMPLE_W-1:0] d,
                                       input int unsigned skip, input int unsigned w);
    lad_posts_t p;
    p    = '0;
    p[0] = clk;
    for (int k = 0; k < SAMPLE_W; k++) begin
      if (k < w) begin
        p[1+skip+k] = d[k];
      end
    end
    return p;
  endfunction

  // ---------------------------------------------------------------
  // Link domain: reset, configuration and frame crossing
  // ---------------------------------------------------------------
  logic                      lnk_rst;
  logic [5:0]                lnk_cfg;
  lad_fmt_e                  lnk_fmt;
  logic                      lnk_fall_first;
  logic                      frame_s;
  logic                      frame_prev_q;
  logic                      frame_edge;
  logic                      lnk_serial;

  lad_sync #(.W(1)) u_rst_sync (
    .i_clock (i_bit_clock),
    .i_rst   (1'b0),
    .i_d     (i_sys_rst),
    .o_q     (lnk_rst)
  );

  lad_sync #(.W(6)) u_cfg_sync (
    .i_clock (i_bit_clock),
    .i_rst   (lnk_rst),
    .i_d     ({i_format, i_fall_first}),
    .o_q     (lnk_cfg)
  );

  lad_sync #(.W(1)) u_frame_sync (
    .i_clock (i_bit_clock),
    .i_rst   (lnk_rst),
    .i_d     (i_frame_clock_in),
    .o_q     (frame_s)
  );

  assign lnk_fmt        = lad_fmt_e'(lnk_cfg[5:1]);
  assign lnk_fall_first = lnk_cfg[0];
  assign lnk_serial     = (lnk_fmt == FMT_SER_1W) || (lnk_fmt == FMT_SER_2W);
  assign frame_edge     = frame_s & ~frame_prev_q & lnk_serial;

  always_ff @(posedge i_bit_clock) begin
    if (lnk_rst) begin
      frame_prev_q <= 1'b0;
    end else begin
      frame_prev_q <= frame_s;
    end
  end

  // ---------------------------------------------------------------
  // Link domain: DDR capture on both edges
  // ---------------------------------------------------------------
  logic [DATA_PAIRS-1:0] rise_q;
  logic [DATA_PAIRS-1:0] fall_q;
  logic [DATA_PAIRS-1:0] first_b;
  logic [DATA_PAIRS-1:0] second_b;

  always_ff @(negedge i_bit_clock) begin
    if (lnk_rst) begin
      fall_q <= '0;
    end else begin
      fall_q <= i_data_pairs;
    end
  end

  always_ff @(posedge i_bit_clock) begin
    if (lnk_rst) begin
      rise_q <= '0;
    end else begin
      rise_q <= i_data_pairs;
    end
  end

  assign first_b  = lnk_fall_first ? fall_q : rise_q;
  assign second_b = lnk_fall_first ? rise_q : fall_q;

  // ---------------------------------------------------------------
  // Link domain: serial lanes
  // ---------------------------------------------------------------
  logic [SER_LANES-1:0][SAMPLE_W-1:0] lane_word;
  logic                               frame_done_q;

  for (genvar g = 0; g < SER_LANES; g++) begin : g_lane
    lad_lane u_lane (
      .i_clock      (i_bit_clock),
      .i_rst        (lnk_rst),
      .i_bit        (i_data_pairs[g]),
      .i_frame_edge (frame_edge),
      .o_word       (lane_word[g])
    );
  end

  always_ff @(posedge i_bit_clock) begin
    if (lnk_rst) begin
      frame_done_q <= 1'b0;
    end else begin
      frame_done_q <= frame_edge;
    end
  end

  // ---------------------------------------------------------------
  // Link domain: assemble sample set, flag with a toggle
  // ---------------------------------------------------------------
  lad_set_s lnk_set_d;
  lad_set_s lnk_set_q;
  logic     lnk_tgl_q;
  logic     lnk_new;

  always_comb begin
    lnk_set_d = '0;
    unique case (lnk_fmt)
      FMT_DDR_BIT1: begin
        lnk_set_d.ch[0] = interleave(first_b[DDR_BIT_PRS-1:0],
                                     second_b[DDR_BIT_PRS-1:0]);
      end
      FMT_DDR_SMP1: begin
        lnk_set_d.ch[0] = {{(SAMPLE_W-NARROW_W){1'b0}}, first_b};
      end
      FMT_DDR_BIT2: begin
        lnk_set_d.ch[0] = interleave({1'b0, first_b[CH2_PAIRS-1:0]},
                                     {1'b0, second_b[CH2_PAIRS-1:0]});
        lnk_set_d.ch[1] = interleave({1'b0, first_b[DATA_PAIRS-1:CH2_PAIRS]},
                                     {1'b0, second_b[DATA_PAIRS-1:CH2_PAIRS]});
      end
      FMT_SER_1W: begin
        lnk_set_d.ch = lane_word;
      end
      FMT_SER_2W: begin
        for (int c = 0; c < SER_HDRS; c++) begin
          lnk_set_d.ch[c] = {lane_word[2*c][HALF_W-1:0], lane_word[2*c+1][HALF_W-1:0]};
        end
      end
      default: begin
        lnk_set_d = '0;
      end
    endcase
  end

  assign lnk_new = lnk_serial ? frame_done_q : 1'b1;

  // Set is held a full link period, longer than the toggle crossing
  always_ff @(posedge i_bit_clock) begin
    if (lnk_rst) begin
      lnk_set_q <= '0;
      lnk_tgl_q <= 1'b0;
    end else if (lnk_new) begin
      lnk_set_q <= lnk_set_d;
      lnk_tgl_q <= ~lnk_tgl_q;
    end
  end

  // ---------------------------------------------------------------
  // System domain: take each new sample set
  // ---------------------------------------------------------------
  logic     tgl_s;
  logic     tgl_prev_q;
  logic     new_smp;
  lad_set_s set_q;

  lad_sync #(.W(1)) u_tgl_sync (
    .i_clock (i_clock),
    .i_rst   (i_sys_rst),
    .i_d     (lnk_tgl_q),
    .o_q     (tgl_s)
  );

  assign new_smp = tgl_s ^ tgl_prev_q;

  always_ff @(posedge i_clock) begin
    if (i_sys_rst) begin
      tgl_prev_q <= 1'b0;
      set_q      <= '0;
    end else begin
      tgl_prev_q <= tgl_s;
      if (new_smp) begin
        set_q <= lnk_set_q;
      end
    end
  end

  // ---------------------------------------------------------------
  // Output headers
  // ---------------------------------------------------------------
  logic [1:0] hclk_cnt_q;
  logic       hclk;

  always_ff @(posedge i_clock) begin
    if (i_sys_rst) begin
      hclk_cnt_q <= '0;
    end else if (new_smp) begin
      hclk_cnt_q <= HDR_CLK_HIGH;
    end else if (hclk_cnt_q != '0) begin
      hclk_cnt_q <= hclk_cnt_q - 2'h1;
    end
  end

  assign hclk = (hclk_cnt_q != '0);

  for (genvar h = 0; h < NUM_HDR; h++) begin : g_hdr
    localparam int unsigned SKIP = (h == 0) ? SKIP_FIRST : SKIP_OTHER;
    localparam int unsigned W    = (h < WIDE_HDRS) ? WIDE_W : NARROW_W;
    logic                ena;
    logic [SAMPLE_W-1:0] src;

    always_comb begin
      ena = 1'b0;
      src = set_q.ch[h];
      if (i_format == FMT_SER_1W) begin
        ena = (h < SER_HDRS);
        src = set_q.ch[(h + (i_upper_bank ? SER_HDRS : 0)) % NUM_CH];
      end else if (i_format == FMT_SER_2W) begin
        ena = (h < SER_HDRS);
      end else begin
        ena = i_ddr_hdr_en && (h < WIDE_HDRS);
      end
    end

    always_ff @(posedge i_clock) begin
      if (i_sys_rst) begin
        o_header[h] <= '0;
      end else if (ena) begin
        o_header[h] <= posts(hclk, src, SKIP, W);
      end else begin
        o_header[h] <= '0;
      end
    end
  end

  // ---------------------------------------------------------------
  // Capture record and host serial stream
  // ---------------------------------------------------------------
  logic [CAP_DEPTH-1:0][SAMPLE_W-1:0] mem_q;
  logic [CAP_AW-1:0]                  wr_idx_q;
  logic [CAP_AW-1:0]                  rd_idx_q;
  logic [CAP_AW-1:0]                  last_idx;
  logic                               hi_byte_q;
  logic [UART_BITS-1:0]               tx_sh_q;
  logic [3:0]                         tx_left_q;
  logic [9:0]                         baud_cnt_q;
  logic [9:0]                         baud_div;
  logic                               baud_tick;
  logic                               tx_idle;

  always_comb begin
    unique case (i_baud_sel)
      BAUD_SEL_LOW:  baud_div = DIV_LOW;
      BAUD_SEL_MID:  baud_div = DIV_MID;
      BAUD_SEL_HIGH: baud_div = DIV_HIGH;
      default:       baud_div = DIV_LOW;
    endcase
  end

  // Zero length captures one word; longer than the store is clamped
  assign last_idx  = (i_cap_len == '0) ? '0 :
                     (i_cap_len > CAP_DEPTH[CAP_AW:0]) ? {CAP_AW{1'b1}} :
                     CAP_AW'(i_cap_len - 5'h01);
  assign baud_tick = (baud_cnt_q == '0);
  assign tx_idle   = (tx_left_q == '0);

  always_ff @(posedge i_clock) begin
    if (i_sys_rst || i_fifo_clear) begin
      o_cap_state <= CAP_IDLE;
      wr_idx_q    <= '0;
      rd_idx_q    <= '0;
      hi_byte_q   <= 1'b0;
    end else begin
      unique case (o_cap_state)
        CAP_IDLE: begin
          if (i_cap_start) begin
            o_cap_state <= CAP_FILL;
            wr_idx_q    <= '0;
          end
        end
        CAP_FILL: begin
          if (new_smp) begin
            wr_idx_q <= wr_idx_q + 1'b1;
            if (wr_idx_q == last_idx) begin
              o_cap_state <= CAP_SEND;
              rd_idx_q    <= '0;
              hi_byte_q   <= 1'b0;
            end
          end
        end
        CAP_SEND: begin
          if (tx_idle) begin
            hi_byte_q <= ~hi_byte_q;
            if (hi_byte_q) begin
              rd_idx_q <= rd_idx_q + 1'b1;
              if (rd_idx_q == last_idx) begin
                o_cap_state <= CAP_IDLE;
              end
            end
          end
        end
        default: begin
          o_cap_state <= CAP_IDLE;
        end
      endcase
    end
  end

  // Clear rewinds the indices and idles capture, leaving the words; the words left behind are never sent
  always_ff @(posedge i_clock) begin
    if (i_sys_rst) begin
      mem_q <= '0;
    end else if (o_cap_state == CAP_FILL && new_smp) begin
      mem_q[wr_idx_q] <= set_q.ch[i_cap_chan] ;
    end
  end

  always_ff @(posedge i_clock) begin
    if (i_sys_rst) begin
      tx_sh_q    <= {UART_BITS{TX_IDLE}};
      tx_left_q  <= '0;
      baud_cnt_q <= '0;
      o_uart_tx  <= TX_IDLE;
    end else if (tx_idle) begin
      if (o_cap_state == CAP_SEND) begin
        tx_sh_q    <= {1'b1, hi_byte_q ? mem_q[rd_idx_q][15:8] : mem_q[rd_idx_q][7:0], 1'b0};
        tx_left_q  <= 4'(UART_BITS + 1);
        baud_cnt_q <= '0;
      end
      o_uart_tx <= TX_IDLE;
    end else begin
      baud_cnt_q <= baud_tick ? baud_div - 10'h001 : baud_cnt_q - 10'h001;
      if (baud_tick) begin
        o_uart_tx <= tx_sh_q[0];
        tx_sh_q   <= {TX_IDLE, tx_sh_q[UART_BITS-1:1]};
        tx_left_q <= tx_left_q - 4'h1;
      end
    end
  end

  // ---------------------------------------------------------------
  // Converter configuration port
  // ---------------------------------------------------------------
  logic [SPI_BITS-1:0] spi_sh_q;
  logic [4:0]          spi_left_q;
  logic [3:0]          spi_div_q;

  always_ff @(posedge i_clock) begin
    if (i_sys_rst) begin
      o_spi.select_n <= SEL_N_IDLE;
      o_spi.sclk     <= 1'b0;
      o_spi.config_serial_data    <= 1'b0;
      o_spi_busy     <= 1'b0;
      spi_sh_q       <= '0;
      spi_left_q     <= '0;
      spi_div_q      <= '0;
    end else if (!o_spi_busy) begin
      if (i_spi_req.start) begin
        o_spi_busy     <= 1'b1;
        o_spi.select_n <= 1'b0;
        o_spi.config_serial_data    <= i_spi_req.word[SPI_BITS-1];
        spi_sh_q       <= {i_spi_req.word[SPI_BITS-2:0], 1'b0};
        spi_left_q     <= 5'(SPI_BITS);
        spi_div_q      <= 4'(SPI_HALF_CYC - 1);
      end
    end else if (spi_div_q != '0) begin
      spi_div_q <= spi_div_q - 4'h1;
    end else begin
      spi_div_q  <= 4'(SPI_HALF_CYC - 1);
      o_spi.sclk <= ~o_spi.sclk;
      if (o_spi.sclk) begin
        if (spi_left_q == 5'h01) begin
          o_spi.select_n <= SEL_N_IDLE;
          o_spi_busy     <= 1'b0;
        end else begin
          o_spi.config_serial_data <= spi_sh_q[SPI_BITS-1];
          spi_sh_q    <= {spi_sh_q[SPI_BITS-2:0], 1'b0};
        end
        spi_left_q <= spi_left_q - 5'h01;
      end
    end
  end

  // Converter reset and power-down held inactive here
  always_ff @(posedge i_clock) begin
    o_conv_reset <= CONV_RST_IDLE;
    o_conv_pdn   <= CONV_PDN_IDLE;
  end

endmodule
`default_nettype wire

// [dv/lad_conv_model.sv]
`timescale 1ns/10ps
`default_nettype none
module lad_conv_model
  import lad_pkg::*;
(
  input  wire logic                  i_bit_clock, // Link bit clock
  input  wire logic [4:0]            i_nbits,     // Bits per frame
  input  wire lad_set_s              i_words,     // Word per lane
  output logic                       o_frame,     // Frame clock
  output logic [DATA_PAIRS-1:0]      o_pairs      // Data pairs
);
  int k = 0;
  initial begin
    o_frame = 1'b0;
    o_pairs = '0;
  end
  // Launch on the falling edge so the rising capture edge sees settled data
  always @(negedge i_bit_clock) begin
    for (int l = 0; l < SER_LANES; l++) begin
      o_pairs[l] <= i_words.ch[l][i_nbits - 1 - k];
    end
    o_pairs[DATA_PAIRS-1:SER_LANES] <= ~o_pairs[DATA_PAIRS-1:SER_LANES];
    o_frame <= (k < i_nbits / 2);
    k <= (k + 1 >= i_nbits) ? 0 : k + 1;
  end
endmodule
`default_nettype wire

// [dv/lad_top_monitor.sv]
`timescale 1ns/10ps
`default_nettype none
module lad_top_monitor
  import lad_pkg::*;
(
  input  wire logic                       i_clock,      // System clock
  input  wire logic                       i_sys_rst,    // Sync reset
  input  wire lad_fmt_e                   i_format,     // Link format
  input  wire logic                       i_ddr_hdr_en, // DDR headers on
  input  wire lad_spi_req_s               i_spi_req,    // SPI write
  input  wire logic                       i_cap_start,  // Capture start
  input  wire logic                       i_fifo_clear, // Empty store
  input  wire lad_posts_t [NUM_HDR-1:0]   o_header,     // Header posts
  input  wire lad_spi_s                   o_spi,        // Converter SPI
  input  wire logic                       o_spi_busy,   // SPI active
  input  wire logic                       o_conv_reset, // Converter reset
  input  wire logic                       o_conv_pdn,   // Converter pdn
  input  wire lad_cap_e                   o_cap_state   // Capture state
);
  default clocking cb @(posedge i_clock); endclocking
  default disable iff (i_sys_rst);
  logic ser;
  assign ser = (i_format == FMT_SER_1W) || (i_format == FMT_SER_2W);
  sequence spi_go;
    i_spi_req.start && !o_spi_busy;
  endsequence
  sequence spi_open;
    o_spi_busy && !o_spi.select_n;
  endsequence
  a_conv_lines_idle: assert property (!o_conv_reset && !o_conv_pdn)
    else $error("converter reset or power-down active");
  a_spi_frame_open: assert property (spi_go |=> spi_open)
    else $error("spi frame not opened");
  a_spi_rest_state: assert property (o_spi.select_n |-> !o_spi.sclk && !o_spi_busy)
    else $error("spi clock or busy while deselected");
  a_cap_fill_entry: assert property (i_cap_start && !i_fifo_clear && o_cap_state == CAP_IDLE
    |=> o_cap_state == CAP_FILL) else $error("capture did not start");
  a_clear_to_idle: assert property (i_fifo_clear |=> o_cap_state == CAP_IDLE)
    else $error("clear did not idle capture");
  a_ddr_hdr_off: assert property ((!ser && !i_ddr_hdr_en) [*3] |=> o_header == '0)
    else $error("header active in ddr");
  a_hdr_upper_quiet: assert property (ser [*2] |=> o_header[7:4] == '0)
    else $error("upper headers active in serial");
  a_hdr_spare_posts: assert property (o_header[0][3:1] == 3'h0 && o_header[1][1] == 1'b0
    && o_header[1][19:18] == 2'h0 && o_header[2][19:16] == 4'h0)
    else $error("unused header post driven");
endmodule
bind lad_top lad_top_monitor i_mon (.*);
`default_nettype wire

// [dv/tb_lad_top.sv]
`timescale 1ns/10ps
`default_nettype none
module tb_lad_top;
  import lad_pkg::*;
  logic i_clock, i_sys_rst, i_bit_clock, frame, cap_start, clear, upper;
  logic [13:0] pairs, spares;
  logic [4:0] nbits;
  lad_fmt_e fmt;
  lad_spi_req_s spi_req;
  lad_set_s words;
  lad_posts_t [NUM_HDR-1:0] hdr;
  lad_spi_s spi;
  logic busy, c_rst, c_pdn, tx;
  lad_cap_e st;
  int mismatches = 0;
  int checked = 0;
  lad_top i_dut (.i_clock(i_clock), .i_sys_rst(i_sys_rst), .i_bit_clock(i_bit_clock),
    .i_frame_clock_in(frame), .i_data_pairs(pairs), .i_spare_pairs(spares), .i_format(fmt),
    .i_fall_first(1'b0), .i_ddr_hdr_en(1'b0), .i_upper_bank(upper), .i_spi_req(spi_req),
    .i_cap_start(cap_start), .i_cap_chan(3'h0), .i_cap_len(5'h01), .i_fifo_clear(clear),
    .i_baud_sel(BAUD_SEL_HIGH), .o_header(hdr), .o_spi(spi), .o_spi_busy(busy),
    .o_conv_reset(c_rst), .o_conv_pdn(c_pdn), .o_uart_tx(tx), .o_cap_state(st));
  lad_conv_model i_conv (.i_bit_clock(i_bit_clock), .i_nbits(nbits), .i_words(words),
    .o_frame(frame), .o_pairs(pairs));
  initial begin
    i_clock = 1'b0;
    forever #12.5 i_clock = ~i_clock;
  end
  initial begin
    i_bit_clock = 1'b0;
    #7;
    forever #62.5 i_bit_clock = ~i_bit_clock;
  end
  // Spare pairs churn so any accidental use shows up in the headers
  always @(negedge i_bit_clock) spares <= ~spares;
  task automatic cmp(string what, logic [15:0] exp, logic [15:0] got);
    checked++;
    if (got !== exp) begin
      mismatches++;
      $display("BAD %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic summarize;
    $display("checked %0d mismatches %0d", checked, mismatches);
    if (mismatches == 0 && checked > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask
  task automatic t_reset;
    cmp("uart idle", 16'h1, 16'(tx));
    cmp("spi idle", 16'h4, 16'(spi));
    cmp("conv lines", 16'h0, {14'h0, c_rst, c_pdn});
    cmp("cap state", 16'(CAP_IDLE), 16'(st));
    $display("test reset done");
  endtask
  task automatic t_spi(input logic [15:0] w);
    logic [15:0] got;
    logic prev;
    int n;
    got = '0;
    prev = 1'b0;
    n = 0;
    spi_req = '{start: 1'b1, word: w};
    @(negedge i_clock);
    spi_req.start = 1'b0;
    for (int c = 0; c < 300; c++) begin
      if (spi.sclk && !prev) begin
        got = {got[14:0], spi.config_serial_data};
        n++;
      end
      prev = spi.sclk;
      @(negedge i_clock);
    end
    cmp("spi word", w, got);
    cmp("spi clocks", 16'h10, 16'(n));
    $display("test spi done");
  endtask
  task automatic t_serial(input lad_fmt_e f, input logic up, input logic [4:0] nb);
    logic [15:0] e;
    logic [15:0] g;
    fmt = f;
    upper = up;
    nbits = nb;
    for (int h = 0; h < 4; h++) begin
      e = (f == FMT_SER_2W) ? {words.ch[2*h][7:0], words.ch[2*h+1][7:0]}
                            : words.ch[h + (up ? 4 : 0)];
      if (h > 1)
        e = e & 16'h3FFF;
      for (int c = 0; c < 2000; c++) begin
        g = (h == 0) ? hdr[0][19:4] : (h == 1) ? hdr[1][17:2] : {2'h0, hdr[h][15:2]};
        if (g === e)
          break;
        @(negedge i_clock);
      end
      cmp("header data", e, g);
    end
    $display("test serial done");
  endtask
  task automatic wait_st(input lad_cap_e s, input int n);
    for (int c = 0; c < n && st !== s; c++) @(negedge i_clock);
    cmp("cap state", 16'(s), 16'(st));
  endtask
  task automatic t_capture;
    logic [9:0] rx;
    cap_start = 1'b1;
    @(negedge i_clock);
    cap_start = 1'b0;
    cmp("fill", 16'(CAP_FILL), 16'(st));
    wait_st(CAP_SEND, 2000);
    while (tx) @(negedge i_clock);
    repeat (DIV_HIGH / 2) @(negedge i_clock);
    for (int b = 0; b < 10; b++) begin
      rx = {tx, rx[9:1]};
      repeat (DIV_HIGH) @(negedge i_clock);
    end
    cmp("uart frame", {7'h1, words.ch[1][7:0], 1'b0}, 16'(rx));
    wait_st(CAP_IDLE, 4000);
    cap_start = 1'b1;
    @(negedge i_clock);
    cap_start = 1'b0;
    clear = 1'b1;
    @(negedge i_clock);
    clear = 1'b0;
    cmp("cleared", 16'(CAP_IDLE), 16'(st));
    $display("test capture done");
  endtask
  initial begin
    #2_000_000;
    mismatches++;
    summarize();
  end
  initial begin
    i_sys_rst = 1'b1;
    {cap_start, clear, upper} = '0;
    spares = 14'h2A55;
    nbits = 5'h10;
    fmt = FMT_DDR_BIT1;
    spi_req = '0;
    for (int l = 0; l < 8; l++) words.ch[l] = 16'hC3A1 ^ (16'h1111 * 16'(l));
    repeat (24) @(negedge i_clock);
    i_sys_rst = 1'b0;
    @(negedge i_clock);
    t_reset();
    t_spi(16'hA53C);
    t_spi(16'h0F81);
    t_serial(FMT_SER_1W, 1'b0, 5'h10);
    t_serial(FMT_SER_1W, 1'b1, 5'h10);
    t_serial(FMT_SER_2W, 1'b0, 5'h08);
    t_capture();
    summarize();
  end
endmodule
`default_nettype wire
